// ==== verilog/status_pkg.sv ====
// Purpose: Shared constants and command codes for the status reporting registers
// Assumes: 16-bit status registers, one 10 MHz clock
// Notes:   Bit positions and reset values live here only

package status_pkg;

    // ********************************************
    // Register geometry
    // ********************************************
    localparam int          REG_W          = 16;
    localparam int          SYNC_STAGES    = 3;

    // ********************************************
    // Operation group bit positions
    // ********************************************
    localparam int          OPER_CAL_BIT   = 0;
    localparam int          OPER_TRIG_BIT  = 5;
    localparam int          OPER_VREG_BIT  = 8;
    localparam int          OPER_IREG_BIT  = 10;
    localparam int          OPER_SEQ_BIT   = 14;
    localparam logic [15:0] OPER_VALID     = 16'h4521;

    // ********************************************
    // Fault group bit positions
    // ********************************************
    localparam int          QUES_OV_BIT    = 0;
    localparam int          QUES_OC_BIT    = 1;
    localparam int          QUES_LEAD_BIT  = 2;
    localparam int          QUES_TEMP_BIT  = 3;
    localparam int          QUES_SRC_BIT   = 4;
    localparam int          QUES_FAN_BIT   = 5;
    localparam logic [15:0] QUES_VALID     = 16'h003f;

    // ********************************************
    // Summary bits and reset values
    // ********************************************
    localparam int          STB_OPER_BIT   = 7;
    localparam int          STB_QUES_BIT   = 3;
    localparam logic [15:0] MASK_RST       = 16'h0000;
    localparam logic [15:0] OPER_EVENT_RST = 16'h0000;
    localparam logic [15:0] QUES_EVENT_RST = 16'h0010;
    localparam logic        OUT_ON_RST     = 1'b0;

    // ********************************************
    // Host command codes
    // ********************************************
    typedef enum logic [3:0] {
        OP_OPER_COND,
        OP_OPER_EVENT,
        OP_OPER_MASK_RD,
        OP_OPER_MASK_WR,
        OP_QUES_COND,
        OP_QUES_EVENT,
        OP_QUES_MASK_RD,
        OP_QUES_MASK_WR,
        OP_PRESET,
        OP_OUT_WR,
        OP_OUT_RD
    } cmd_op_e;

endpackage

// ==== verilog/group_if.sv ====
// Purpose: Carrier between the top and one status group
// Assumes: Width set by the instantiating module
// Notes:   Top drives controls, group returns its registers

`timescale 1ns/1ns
`default_nettype none

interface group_if #(
    parameter int W = 16
);
    logic [W-1:0] cond_raw;
    logic         preset;
    logic         mask_we;
    logic [W-1:0] mask_wdata;
    logic         event_rd;
    logic [W-1:0] cond_q;
    logic [W-1:0] event_q;
    logic [W-1:0] mask_q;
    logic         summary;

    modport owner (
        output cond_raw, preset, mask_we, mask_wdata, event_rd,
        input  cond_q, event_q, mask_q, summary
    );
    modport group (
        input  cond_raw, preset, mask_we, mask_wdata, event_rd,
        output cond_q, event_q, mask_q, summary
    );
endinterface

`default_nettype wire

// ==== verilog/status_group.sv ====
// Purpose: One condition / event / mask register group with summary
// Assumes: cond_raw already synchronised to core_clk
// Notes:   Events latch on a 0 to 1 change of a condition bit

`timescale 1ns/1ns
`default_nettype none

module status_group #(
    parameter int              W         = 16,
    parameter logic [W-1:0]    VALID     = '1,
    parameter logic [W-1:0]    EVENT_RST = '0,
    parameter logic [W-1:0]    MASK_INIT = '0
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic nrst,
    // Group port
    group_if.group    gi
);

    logic [W-1:0] cond_q, cond_d;
    logic [W-1:0] event_q, event_d;
    logic [W-1:0] mask_q, mask_d;
    logic [W-1:0] rise;

    initial begin
        if (W < 1 || W > 16) $error("status_group width out of range");
    end

    // ********************************************
    // Next-state logic
    // ********************************************
    // Condition follows the input live; preset forces it to zero
    always_comb begin
        cond_d  = gi.preset ? '0 : (gi.cond_raw & VALID);
        rise    = cond_d & ~cond_q & VALID;
        // Read clears, but an edge in the read cycle survives
        event_d = (gi.event_rd ? '0 : event_q) | rise;
        mask_d  = gi.mask_we ? (gi.mask_wdata & VALID) : mask_q;
    end

    // Registers only
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cond_q  <= '0;
            event_q <= EVENT_RST;
            mask_q  <= MASK_INIT;
        end else begin
            cond_q  <= cond_d;
            event_q <= event_d;
            mask_q  <= mask_d;
        end
    end

    assign gi.cond_q  = cond_q;
    assign gi.event_q = event_q;
    assign gi.mask_q  = mask_q;
    assign gi.summary = |(event_q & mask_q);

    // ********************************************
    // Checks
    // ********************************************
    a_event_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        !gi.event_rd |=> ((event_q & $past(event_q)) == $past(event_q)))
        else $error("event bit lost without a read");
    a_edge_caught: assert property (@(posedge core_clk) disable iff (!nrst)
        (rise != '0) |=> ((event_q & $past(rise)) == $past(rise)))
        else $error("condition edge not latched");
    a_preset_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        gi.preset |=> (cond_q == '0))
        else $error("condition not cleared by preset");
    a_unused_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        ((cond_q | event_q | mask_q) & ~VALID) == '0)
        else $error("unused bit set");

endmodule

`default_nettype wire

// ==== verilog/status_regs.sv ====
// Purpose: Status reporting registers of a programmable supply
// Assumes: Host commands arrive already decoded on cmd_* ports
// Notes:   Answer comes one cycle after every command
//
// Operation
// - Operation condition shows the present state live, unlatched.
// - Operation bits: 0 calibration, 5 trigger wait, 8 CV, 10 CC, 14 sequence.
// - Operation reads return only the defined bits.
// - Status bit 7 is the OR of enabled operation events.
// - Operation mask write stores only the defined bits; a read returns them.
// - Operation events latch; a read returns them then clears.
// - An operation event marks a condition bit going from 0 to 1 since the last read.
// - Preset forces both condition registers to zero.
// - Fault bits: 0 overvoltage to 5 cooling; bits 6 to 15 unused.
// - Fault events latch; a read returns them then clears.
// - Source loss event is held over power loss; first read shows it.
// - Fault condition is live and drops when the fault ends.
// - Status bit 3 is the OR of enabled fault events.
// - Fault mask write stores; a read returns it.
// - Overvoltage trip turns the output off and it stays off.
// - Overvoltage forces output to zero and sets its condition bit.

`timescale 1ns/1ns
`default_nettype none

module status_regs
    import status_pkg::*;
#(
    parameter int W = status_pkg::REG_W
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                nrst,
    // Operating state pins
    input  wire logic                cal_busy,
    input  wire logic                awaiting_trigger,
    input  wire logic                voltage_regulating,
    input  wire logic                current_regulating,
    input  wire logic                sequence_running,
    // Fault pins
    input  wire logic                overvoltage_trip,
    input  wire logic                overcurrent_trip,
    input  wire logic                lead_fault,
    input  wire logic                over_temperature,
    input  wire logic                source_loss,
    input  wire logic                cooling_failure,
    // Host command port
    input  wire logic                cmd_valid,
    input  wire status_pkg::cmd_op_e cmd_op,
    input  wire logic [W-1:0]        cmd_wdata,
    output logic                     rsp_valid,
    output logic [W-1:0]             rsp_data,
    // Status and output control
    output logic [7:0]               status_byte,
    output logic                     output_enable
);
    import status_pkg::*;

    initial begin
        if (W != REG_W) $error("status_regs supports only 16-bit registers");
    end

    // ********************************************
    // Pin synchronisers
    // ********************************************
    logic [W-1:0] oper_pins, ques_pins;
    logic [W-1:0] oper_s1_q, oper_s2_q, oper_s3_q, oper_clean_q;
    logic [W-1:0] ques_s1_q, ques_s2_q, ques_s3_q, ques_clean_q;
    logic [W-1:0] oper_clean_d, ques_clean_d;

    // Place each pin at its register bit
    always_comb begin
        oper_pins                = '0;
        oper_pins[OPER_CAL_BIT]  = cal_busy;
        oper_pins[OPER_TRIG_BIT] = awaiting_trigger;
        oper_pins[OPER_VREG_BIT] = voltage_regulating;
        oper_pins[OPER_IREG_BIT] = current_regulating;
        oper_pins[OPER_SEQ_BIT]  = sequence_running;
        ques_pins                = '0;
        ques_pins[QUES_OV_BIT]   = overvoltage_trip;
        ques_pins[QUES_OC_BIT]   = overcurrent_trip;
        ques_pins[QUES_LEAD_BIT] = lead_fault;
        ques_pins[QUES_TEMP_BIT] = over_temperature;
        ques_pins[QUES_SRC_BIT]  = source_loss;
        ques_pins[QUES_FAN_BIT]  = cooling_failure;
    end

    // A change counts only once stages two and three agree
    always_comb begin
        oper_clean_d = (oper_s2_q ^ oper_s3_q) & oper_clean_q
                     | ~(oper_s2_q ^ oper_s3_q) & oper_s3_q;
        ques_clean_d = (ques_s2_q ^ ques_s3_q) & ques_clean_q
                     | ~(ques_s2_q ^ ques_s3_q) & ques_s3_q;
    end

    // Synchroniser flops
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            oper_s1_q    <= '0;
            oper_s2_q    <= '0;
            oper_s3_q    <= '0;
            oper_clean_q <= '0;
            ques_s1_q    <= '0;
            ques_s2_q    <= '0;
            ques_s3_q    <= '0;
            ques_clean_q <= '0;
        end else begin
            oper_s1_q    <= oper_pins;
            oper_s2_q    <= oper_s1_q;
            oper_s3_q    <= oper_s2_q;
            oper_clean_q <= oper_clean_d;
            ques_s1_q    <= ques_pins;
            ques_s2_q    <= ques_s1_q;
            ques_s3_q    <= ques_s2_q;
            ques_clean_q <= ques_clean_d;
        end
    end

    // ********************************************
    // Register groups
    // ********************************************
    group_if #(.W(W)) oper_gi ();
    group_if #(.W(W)) ques_gi ();

    status_group #(
        .W         (W),
        .VALID     (OPER_VALID),
        .EVENT_RST (OPER_EVENT_RST),
        .MASK_INIT (MASK_RST)
    ) u_oper (
        .core_clk (core_clk),
        .nrst     (nrst),
        .gi       (oper_gi.group)
    );

    // Source loss event resets set, so it survives a power cycle
    status_group #(
        .W         (W),
        .VALID     (QUES_VALID),
        .EVENT_RST (QUES_EVENT_RST),
        .MASK_INIT (MASK_RST)
    ) u_ques (
        .core_clk (core_clk),
        .nrst     (nrst),
        .gi       (ques_gi.group)
    );

    // ********************************************
    // Command decode
    // ********************************************
    function automatic logic is_op(input logic v, input cmd_op_e op, input cmd_op_e want);
        return v && (op == want);
    endfunction

    // Live inputs steer the conditions; preset zeroes both
    always_comb begin
        oper_gi.cond_raw   = oper_clean_q;
        ques_gi.cond_raw   = ques_clean_q;
        oper_gi.preset     = is_op(cmd_valid, cmd_op, OP_PRESET);
        ques_gi.preset     = is_op(cmd_valid, cmd_op, OP_PRESET);
        oper_gi.mask_we    = is_op(cmd_valid, cmd_op, OP_OPER_MASK_WR);
        ques_gi.mask_we    = is_op(cmd_valid, cmd_op, OP_QUES_MASK_WR);
        oper_gi.mask_wdata = cmd_wdata;
        ques_gi.mask_wdata = cmd_wdata;
        oper_gi.event_rd   = is_op(cmd_valid, cmd_op, OP_OPER_EVENT);
        ques_gi.event_rd   = is_op(cmd_valid, cmd_op, OP_QUES_EVENT);
    end

    // ********************************************
    // Answer path
    // ********************************************
    logic         rsp_valid_q, rsp_valid_d;
    logic [W-1:0] rsp_data_q, rsp_data_d;
    logic         out_on_q, out_on_d;

    // Event reads return the value before the clear takes effect
    always_comb begin
        rsp_valid_d = cmd_valid;
        rsp_data_d  = '0;
        if (cmd_valid) begin
            unique case (cmd_op)
                OP_OPER_COND:    rsp_data_d = oper_gi.cond_q & OPER_VALID;
                OP_OPER_EVENT:   rsp_data_d = oper_gi.event_q & OPER_VALID;
                OP_OPER_MASK_RD: rsp_data_d = oper_gi.mask_q & OPER_VALID;
                OP_QUES_COND:    rsp_data_d = ques_gi.cond_q;
                OP_QUES_EVENT:   rsp_data_d = ques_gi.event_q;
                OP_QUES_MASK_RD: rsp_data_d = ques_gi.mask_q;
                OP_OUT_RD:       rsp_data_d = {{(W-1){1'b0}}, out_on_q};
                default:         rsp_data_d = '0;
            endcase
        end
    end

    // ********************************************
    // Output enable with overvoltage trip
    // ********************************************
    // Trip wins over a same-cycle enable; host must re-enable after the fault
    always_comb begin
        out_on_d = out_on_q;
        if (is_op(cmd_valid, cmd_op, OP_OUT_WR)) begin
            out_on_d = cmd_wdata[0];
        end
        if (ques_clean_q[QUES_OV_BIT]) begin
            out_on_d = 1'b0;
        end
    end

    // Answer and output registers
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= '0;
            out_on_q    <= OUT_ON_RST;
        end else begin
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q  <= rsp_data_d;
            out_on_q    <= out_on_d;
        end
    end

    // Summary bits into the status byte
    always_comb begin
        status_byte               = 8'h00;
        status_byte[STB_OPER_BIT] = oper_gi.summary;
        status_byte[STB_QUES_BIT] = ques_gi.summary;
    end

    assign rsp_valid     = rsp_valid_q;
    assign rsp_data      = rsp_data_q;
    assign output_enable = out_on_q;

    // ********************************************
    // Checks
    // ********************************************
    a_oper_summary: assert property (@(posedge core_clk) disable iff (!nrst)
        status_byte[STB_OPER_BIT] == |(oper_gi.event_q & oper_gi.mask_q))
        else $error("operation summary mismatch");
    a_ques_summary: assert property (@(posedge core_clk) disable iff (!nrst)
        status_byte[STB_QUES_BIT] == |(ques_gi.event_q & ques_gi.mask_q))
        else $error("fault summary mismatch");
    a_oper_range: assert property (@(posedge core_clk) disable iff (!nrst)
        rsp_valid |-> (rsp_data & ~(OPER_VALID | QUES_VALID | 16'h0001)) == '0)
        else $error("answer holds unused bits");
    a_oper_mask_back: assert property (@(posedge core_clk) disable iff (!nrst)
        is_op(cmd_valid, cmd_op, OP_OPER_MASK_WR)
        |=> oper_gi.mask_q == ($past(cmd_wdata) & OPER_VALID))
        else $error("operation mask store wrong");
    a_ques_mask_back: assert property (@(posedge core_clk) disable iff (!nrst)
        is_op(cmd_valid, cmd_op, OP_QUES_MASK_WR)
        |=> ques_gi.mask_q == ($past(cmd_wdata) & QUES_VALID))
        else $error("fault mask store wrong");
    a_event_read: assert property (@(posedge core_clk) disable iff (!nrst)
        is_op(cmd_valid, cmd_op, OP_QUES_EVENT)
        |=> rsp_valid && rsp_data == $past(ques_gi.event_q))
        else $error("fault event read wrong");
    a_ov_trip: assert property (@(posedge core_clk) disable iff (!nrst)
        ques_clean_q[QUES_OV_BIT] |=> !output_enable [*2])
        else $error("output not held off on overvoltage");
    a_ov_cond: assert property (@(posedge core_clk) disable iff (!nrst)
        (ques_clean_q[QUES_OV_BIT] && !ques_gi.preset) |=> ques_gi.cond_q[QUES_OV_BIT])
        else $error("overvoltage condition bit missing");
    a_cond_live: assert property (@(posedge core_clk) disable iff (!nrst)
        (!ques_gi.preset) |=> ques_gi.cond_q == $past(ques_clean_q & QUES_VALID))
        else $error("fault condition not live");

    c_oper_event: cover property (@(posedge core_clk) disable iff (!nrst)
        is_op(cmd_valid, cmd_op, OP_OPER_EVENT) ##1 rsp_data != '0);
    c_ov_trip: cover property (@(posedge core_clk) disable iff (!nrst)
        output_enable ##1 ques_clean_q[QUES_OV_BIT] ##1 !output_enable);
    c_preset: cover property (@(posedge core_clk) disable iff (!nrst)
        is_op(cmd_valid, cmd_op, OP_PRESET) && oper_gi.cond_q != '0);
    c_summary: cover property (@(posedge core_clk) disable iff (!nrst)
        status_byte[STB_OPER_BIT] && status_byte[STB_QUES_BIT]);

endmodule

`default_nettype wire

// ==== test/host_model.sv ====
// Purpose: Host side that issues status commands and collects answers
// Assumes: One command at a time; answer registered on the edge that takes it
// Notes:   Requests change only just after a rising edge

`timescale 1ns/1ns
`default_nettype none

module host_model (
    // Clock
    input  wire logic               core_clk,
    // Command port
    output var logic                cmd_valid,
    output var status_pkg::cmd_op_e cmd_op,
    output var logic [15:0]         cmd_wdata,
    input  wire logic               rsp_valid,
    input  wire logic [15:0]        rsp_data
);
    import status_pkg::*;

    // ********************************************
    // Idle port values at time zero
    // ********************************************
    initial begin
        cmd_valid = 1'b0;
        cmd_op    = OP_OPER_COND;
        cmd_wdata = 16'h0000;
    end

    // One-cycle strobe; answer read once the taking edge has landed
    task automatic send(input cmd_op_e op, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ok);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_op    <= op;
        cmd_wdata <= wd;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        #1;
        ok = rsp_valid;
        rd = rsp_data;
    endtask
endmodule

`default_nettype wire

// ==== test/test_status_reporting_registers.sv ====
// Purpose: Self-checking bench for the status reporting registers
// Assumes: Pins settle within 8 edges; host model drives commands
// Notes:   Table rows first, then reset, preset, clear race, trip

`timescale 1ns/1ns
`default_nettype none

module test_status_reporting_registers;
    import status_pkg::*;

    // ********************************************
    // Signals and table
    // ********************************************
    logic        core_clk = 1'b0;
    logic        nrst     = 1'b0;
    logic [4:0]  opins    = 5'h00;
    logic [5:0]  qpins    = 6'h00;
    logic        cmd_valid;
    cmd_op_e     cmd_op;
    logic [15:0] cmd_wdata;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic [7:0]  status_byte;
    logic        output_enable;
    logic [15:0] got;
    logic [15:0] r1;
    int          err_count  = 0;
    int          num_checks = 0;

    typedef struct packed {
        logic [4:0]  op_pins;
        logic [5:0]  flt_pins;
        logic [15:0] omask;
        logic [15:0] qmask;
        logic [15:0] ocond;
        logic [15:0] qcond;
        logic [15:0] omask_rd;
        logic [15:0] qmask_rd;
        logic [7:0]  stb;
    } row_s;

    // Pins, masks written, expected conditions, mask readback, summary
    row_s rows [4] = '{
        '{5'h06, 6'h00, 16'h0420, 16'h0003, 16'h0120, 16'h0000, 16'h0420, 16'h0003, 8'h80},
        '{5'h09, 6'h03, 16'h0100, 16'h0003, 16'h0401, 16'h0003, 16'h0100, 16'h0003, 8'h08},
        '{5'h10, 6'h3c, 16'hffff, 16'hffff, 16'h4000, 16'h003c, 16'h4521, 16'h003f, 8'h88},
        '{5'h1f, 6'h3f, 16'h0000, 16'h0000, 16'h4521, 16'h003f, 16'h0000, 16'h0000, 8'h00}
    };

    // Clock of 100 ns period
    initial begin
        forever #50 core_clk = ~core_clk;
    end

    // ********************************************
    // Design and host
    // ********************************************
    status_regs i_status_regs (
        .core_clk           (core_clk),
        .nrst               (nrst),
        .cal_busy           (opins[0]),
        .awaiting_trigger   (opins[1]),
        .voltage_regulating (opins[2]),
        .current_regulating (opins[3]),
        .sequence_running   (opins[4]),
        .overvoltage_trip   (qpins[0]),
        .overcurrent_trip   (qpins[1]),
        .lead_fault         (qpins[2]),
        .over_temperature   (qpins[3]),
        .source_loss        (qpins[4]),
        .cooling_failure    (qpins[5]),
        .cmd_valid          (cmd_valid),
        .cmd_op             (cmd_op),
        .cmd_wdata          (cmd_wdata),
        .rsp_valid          (rsp_valid),
        .rsp_data           (rsp_data),
        .status_byte        (status_byte),
        .output_enable      (output_enable)
    );

    host_model i_host_model (
        .core_clk  (core_clk),
        .cmd_valid (cmd_valid),
        .cmd_op    (cmd_op),
        .cmd_wdata (cmd_wdata),
        .rsp_valid (rsp_valid),
        .rsp_data  (rsp_data)
    );

    // ********************************************
    // Shared tasks
    // ********************************************
    task automatic check(input logic [15:0] g, input logic [15:0] e, input string what);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
        end
    endtask

    // Every command must be answered in the next cycle
    task automatic xfer(input cmd_op_e op, input logic [15:0] wd);
        logic ok;
        i_host_model.send(op, wd, got, ok);
        check({15'h0000, ok}, 16'h0001, "answer strobe");
    endtask

    task automatic expect_rd(input cmd_op_e op, input logic [15:0] e, input string what);
        xfer(op, 16'h0000);
        check(got, e, what);
    endtask

    // Pins move on an edge; synchroniser plus register take 5 edges
    task automatic set_pins(input logic [4:0] o, input logic [5:0] q);
        @(posedge core_clk);
        opins <= o;
        qpins <= q;
        repeat (8) @(posedge core_clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Cuts a hang short well past the expected run length
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    // ********************************************
    // Main sequence
    // ********************************************
    initial begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            set_pins(5'h00, 6'h00);
            xfer(OP_OPER_EVENT, 16'h0000);
            xfer(OP_QUES_EVENT, 16'h0000);
            xfer(OP_OPER_MASK_WR, rows[i].omask);
            xfer(OP_QUES_MASK_WR, rows[i].qmask);
            set_pins(rows[i].op_pins, rows[i].flt_pins);
            expect_rd(OP_OPER_COND, rows[i].ocond, "oper cond");
            expect_rd(OP_QUES_COND, rows[i].qcond, "fault cond");
            expect_rd(OP_OPER_MASK_RD, rows[i].omask_rd, "oper mask");
            expect_rd(OP_QUES_MASK_RD, rows[i].qmask_rd, "fault mask");
            check({8'h00, status_byte}, {8'h00, rows[i].stb}, "summary");
            expect_rd(OP_OPER_EVENT, rows[i].ocond, "oper event");
            expect_rd(OP_QUES_EVENT, rows[i].qcond, "fault event");
            expect_rd(OP_OPER_EVENT, 16'h0000, "oper event cleared");
            check({8'h00, status_byte}, 16'h0000, "summary cleared");
        end
        $display("test table rows done");

        // Mid-run reset: source loss event is held, all else clear
        set_pins(5'h00, 6'h00);
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        expect_rd(OP_QUES_EVENT, 16'h0010, "source loss held");
        expect_rd(OP_QUES_EVENT, 16'h0000, "fault event cleared");
        expect_rd(OP_OPER_MASK_RD, 16'h0000, "oper mask reset");
        expect_rd(OP_QUES_MASK_RD, 16'h0000, "fault mask reset");
        check({15'h0000, output_enable}, 16'h0000, "output off at reset");
        $display("test reset done");

        // Preset drops a held condition, so it is seen entering again
        set_pins(5'h04, 6'h00);
        xfer(OP_OPER_EVENT, 16'h0000);
        expect_rd(OP_OPER_COND, 16'h0100, "held cond");
        xfer(OP_PRESET, 16'h0000);
        repeat (8) @(posedge core_clk);
        expect_rd(OP_OPER_EVENT, 16'h0100, "preset re-entry");
        $display("test preset done");

        // Condition edge landing on the clearing read is reported once
        set_pins(5'h00, 6'h00);
        xfer(OP_OPER_EVENT, 16'h0000);
        @(posedge core_clk);
        opins <= 5'h02;
        repeat (3) @(posedge core_clk);
        xfer(OP_OPER_EVENT, 16'h0000);
        r1 = got;
        xfer(OP_OPER_EVENT, 16'h0000);
        check(r1 | got, 16'h0020, "edge at clear kept");
        check(r1 & got, 16'h0000, "edge reported once");
        $display("test clear race done");

        // Overvoltage trip turns the output off and it stays off after the trip ends
        set_pins(5'h00, 6'h00);
        xfer(OP_QUES_EVENT, 16'h0000);
        xfer(OP_OUT_WR, 16'h0001);
        check({15'h0000, output_enable}, 16'h0001, "output on");
        set_pins(5'h00, 6'h01);
        expect_rd(OP_QUES_COND, 16'h0001, "trip cond");
        check({15'h0000, output_enable}, 16'h0000, "output tripped");
        set_pins(5'h00, 6'h00);
        expect_rd(OP_QUES_COND, 16'h0000, "trip gone");
        expect_rd(OP_OUT_RD, 16'h0000, "output stays off");
        expect_rd(OP_QUES_EVENT, 16'h0001, "trip event");
        $display("test overvoltage done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
